//--- bbse_pkg.sv
// Shared constants and types for the branch and bit-set executor.
package bbse_pkg;
    localparam int PC_W = 21;
    localparam int DA_W = 12;
    localparam logic [3:0] OP_NZ_HI = 4'hE;
    localparam logic [3:0] OP_NZ_LO = 4'h1;
    localparam logic [4:0] OP_REL = 5'h1A;
    localparam logic [3:0] OP_SET = 4'h8;
    localparam int SET_A_BIT = 8;
    localparam logic [7:0] LIT_OFS_MAX = 8'h5F;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_BANK = 32'h0000_0004;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_TGT = 32'h0000_000C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_EXT_BIT = 0;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam int Q_PHASES = 4;

    typedef enum logic [1:0] {
        BBSE_ST_IDLE = 2'b00,
        BBSE_ST_EXEC = 2'b01,
        BBSE_ST_NOP = 2'b10
    } bbse_state_t;

    typedef enum logic [1:0] {
        BBSE_OP_NONE = 2'b00,
        BBSE_OP_BR_NZ = 2'b01,
        BBSE_OP_REL_BR = 2'b10,
        BBSE_OP_BIT_SET = 2'b11
    } bbse_op_t;
endpackage

//--- bbse_qgen.sv
// Four-phase instruction cycle enables derived from the core clock.
`timescale 1ns/1ps
module bbse_qgen
    import bbse_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    output logic [Q_PHASES-1:0] q_en
);
    logic [1:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < Q_PHASES; i++) begin : g_ph
            assign q_en[i] = (cnt_r == 2'(i));
        end
    endgenerate
endmodule

//--- bbse_exec.sv
// Executor for branch-if-not-zero, relative branch and bit-set-file.
//
// Summary of operation
// - Branch-if-not-zero jumps when zero flag clear.
// - Relative branch decoded from five-bit pattern.
// - Target is incremented counter plus twice offset.
// - Relative branch always takes two cycles.
// - Relative branch leaves status flags untouched.
// - Bit-set writes one bit, others unchanged.
// - Access bit set uses bank select register.
// - Extended mode low fields use indexed offset when the access bit is clear.
`timescale 1ns/1ps
module bbse_exec
    import bbse_pkg::*;
#(
    parameter logic [7:0] ACC_SPLIT_P = ACC_SPLIT
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    input wire logic [PC_W-1:0] pc_cur,
    input wire logic zero_flag,
    input wire logic [DA_W-1:0] index_base,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    output logic flush_fetch,
    output logic dmem_re,
    output logic [DA_W-1:0] dmem_addr,
    input wire logic [7:0] dmem_rdata,
    output logic dmem_we,
    output logic [7:0] dmem_wdata
);
    logic [Q_PHASES-1:0] q_en;
    bbse_state_t st_r;
    bbse_op_t op_r;
    logic [15:0] ir_r;
    logic taken_r;
    logic ext_en_r;
    logic [3:0] bank_r;
    logic [DA_W-1:0] addr_r;
    logic [7:0] wdata_r;
    logic [PC_W-1:0] tgt_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_go;

    bbse_qgen u_qgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .q_en(q_en)
    );

    function automatic bbse_op_t decode(input logic [15:0] w);
        if (w[15:12] == OP_NZ_HI && w[11:8] == OP_NZ_LO)
            return BBSE_OP_BR_NZ;
        else if (w[15:11] == OP_REL)
            return BBSE_OP_REL_BR;
        else if (w[15:12] == OP_SET)
            return BBSE_OP_BIT_SET;
        else
            return BBSE_OP_NONE;
    endfunction

    // Banked, indexed or access-bank data address for a file operand.
    function automatic logic [DA_W-1:0] file_addr(input logic [15:0] w,
            input logic ext, input logic [3:0] bank,
            input logic [DA_W-1:0] base);
        if (w[SET_A_BIT])
            return {bank, w[7:0]};
        else if (ext && w[7:0] <= LIT_OFS_MAX)
            return base + DA_W'(w[7:0]);
        else if (w[7:0] >= ACC_SPLIT_P)
            return {ACC_HI_BANK, w[7:0]};
        else
            return {ACC_LO_BANK, w[7:0]};
    endfunction

    // Offset is in words, so it is sign extended and doubled.
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
            input logic [10:0] ofs);
        return pc + {{(PC_W-12){ofs[10]}}, ofs, 1'b0};
    endfunction

    assign instr_ready = (st_r == BBSE_ST_IDLE);
    assign flush_fetch = (st_r == BBSE_ST_NOP);
    assign dmem_re = (st_r == BBSE_ST_EXEC) && q_en[2] &&
        op_r == BBSE_OP_BIT_SET;
    assign dmem_we = (st_r == BBSE_ST_EXEC) && q_en[3] &&
        op_r == BBSE_OP_BIT_SET;
    assign pc_load = (st_r == BBSE_ST_EXEC) && q_en[3] && taken_r;
    assign dmem_addr = addr_r;
    assign dmem_wdata = wdata_r;
    assign pc_target = tgt_r;

    // No flag outputs exist here, so status stays untouched.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= BBSE_ST_IDLE;
            op_r <= BBSE_OP_NONE;
            ir_r <= 16'h0000;
        end else begin
            case (st_r)
                BBSE_ST_IDLE: begin
                    if (q_en[0] && instr_valid &&
                            decode(instr_word) != BBSE_OP_NONE) begin
                        ir_r <= instr_word;
                        op_r <= decode(instr_word);
                        st_r <= BBSE_ST_EXEC;
                    end
                end
                BBSE_ST_EXEC: begin
                    if (q_en[3] && taken_r)
                        st_r <= BBSE_ST_NOP;
                    else if (q_en[3])
                        st_r <= BBSE_ST_IDLE;
                end
                BBSE_ST_NOP: begin
                    if (q_en[3])
                        st_r <= BBSE_ST_IDLE;
                end
                default: st_r <= BBSE_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= '0;
        end else if (st_r == BBSE_ST_EXEC && q_en[1]) begin
            addr_r <= file_addr(ir_r, ext_en_r, bank_r, index_base);
        end
    end

    // Read, modify and write all fall inside one instruction cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_r <= 8'h00;
        end else if (dmem_re) begin
            wdata_r <= dmem_rdata | (8'h01 << ir_r[11:9]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taken_r <= 1'b0;
            tgt_r <= '0;
        end else if (st_r == BBSE_ST_EXEC && q_en[2]) begin
            case (op_r)
                BBSE_OP_BR_NZ: begin
                    taken_r <= !zero_flag;
                    tgt_r <= rel_target(pc_cur, {{3{ir_r[7]}}, ir_r[7:0]});
                end
                BBSE_OP_REL_BR: begin
                    taken_r <= 1'b1;
                    tgt_r <= rel_target(pc_cur, ir_r[10:0]);
                end
                default: taken_r <= 1'b0;
            endcase
        end
    end

    // Write address and data are taken only together, so either order works.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_en_r <= CTRL_RST;
            bank_r <= BANK_RST;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= RESP_OKAY;
                case (s_axi_awaddr)
                    ADDR_CTRL: begin
                        if (s_axi_wstrb[0])
                            ext_en_r <= s_axi_wdata[CTRL_EXT_BIT];
                    end
                    ADDR_BANK: begin
                        if (s_axi_wstrb[0])
                            bank_r <= s_axi_wdata[3:0];
                    end
                    ADDR_STAT, ADDR_TGT: ;
                    default: bresp_r <= RESP_SLVERR;
                endcase
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rresp_r <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_CTRL: rdata_r <= 32'(ext_en_r);
                    ADDR_BANK: rdata_r <= 32'(bank_r);
                    ADDR_STAT: rdata_r <= 32'({op_r, st_r});
                    ADDR_TGT: rdata_r <= 32'(tgt_r);
                    default: begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Every check below lives in the core clock domain and sleeps in reset.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_exec_q3(bbse_op_t o);
        st_r == BBSE_ST_EXEC && q_en[2] && op_r == o;
    endsequence

    sequence s_flush_cycle;
        flush_fetch [*4] ##1 !flush_fetch;
    endsequence

    a_nz_jump_taken: assert property (
        s_exec_q3(BBSE_OP_BR_NZ) ##0 !zero_flag |=> pc_load ##1 flush_fetch)
        else $error("not-zero branch did not jump");
    a_nz_fall_through: assert property (
        s_exec_q3(BBSE_OP_BR_NZ) ##0 zero_flag |=> !pc_load ##1 instr_ready)
        else $error("zero branch did not fall through");
    a_rel_decode: assert property (
        (instr_ready && q_en[0] && instr_valid && instr_word[15:11] == OP_REL)
        |=> st_r == BBSE_ST_EXEC && op_r == BBSE_OP_REL_BR)
        else $error("relative branch not decoded");
    a_rel_target: assert property (
        (pc_load && op_r == BBSE_OP_REL_BR) |-> pc_target == $past(pc_cur)
        + PC_W'({{(PC_W-11){ir_r[10]}}, ir_r[10:0]} * 2))
        else $error("relative branch target wrong");
    a_rel_two_cycles: assert property (
        (pc_load && op_r == BBSE_OP_REL_BR) |=> s_flush_cycle)
        else $error("relative branch not two cycles");
    a_set_one_bit: assert property (
        dmem_we |-> dmem_wdata == ($past(dmem_rdata) | (8'h01 << ir_r[11:9])))
        else $error("bit set wrote wrong value");
    a_set_banked_addr: assert property (
        (dmem_re && ir_r[SET_A_BIT]) |-> dmem_addr == {bank_r, ir_r[7:0]})
        else $error("banked address wrong");
    a_set_indexed_addr: assert property (
        (dmem_re && !ir_r[SET_A_BIT] && ext_en_r && ir_r[7:0] <= LIT_OFS_MAX
        && $stable(index_base)) |-> dmem_addr == index_base + DA_W'(ir_r[7:0]))
        else $error("indexed address wrong");
    a_set_access_bank: assert property (
        (dmem_re && !ir_r[SET_A_BIT] && !ext_en_r)
        |-> dmem_addr[7:0] == ir_r[7:0] && dmem_addr[DA_W-1:8] ==
        (ir_r[7:0] >= ACC_SPLIT_P ? ACC_HI_BANK : ACC_LO_BANK))
        else $error("access bank address wrong");
    a_set_single_cycle: assert property (
        dmem_re |=> dmem_we ##1 instr_ready)
        else $error("bit set not single cycle");
endmodule

//--- bbse_tb.sv
// Self-checking bench for the branch and bit-set executor.
`timescale 1ns/1ps
module testbench;
    import bbse_pkg::*;
    logic aclk, aresetn;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    logic instr_valid, instr_ready, zero_flag, pc_load, flush_fetch;
    logic [15:0] instr_word;
    logic [PC_W-1:0] pc_cur, pc_target;
    logic [DA_W-1:0] index_base, dmem_addr;
    logic dmem_re, dmem_we;
    logic [7:0] dmem_rdata, dmem_wdata;
    int error_cnt = 0;
    int num_checks = 0;

    bbse_exec dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready),
        .pc_cur(pc_cur), .zero_flag(zero_flag), .index_base(index_base),
        .pc_load(pc_load), .pc_target(pc_target),
        .flush_fetch(flush_fetch), .dmem_re(dmem_re),
        .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
        .dmem_we(dmem_we), .dmem_wdata(dmem_wdata));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
            error_cnt++;
        end
    endtask

    task timed_out;
        $display("wait limit reached at %0t", $time);
        error_cnt++;
        stop_test();
    endtask

    // Address and data go out together; each is dropped once taken.
    task axi_wr(input logic [31:0] a, input logic [31:0] d,
                input logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                chk(bresp, r);
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) timed_out();
    endtask

    task axi_rd(input logic [31:0] a, input logic [31:0] d,
                input logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                chk(rdata, d);
                chk(rresp, r);
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) timed_out();
    endtask

    // Returns settled inside the third cycle of the instruction.
    task issue(input logic [15:0] w);
        int n;
        @(posedge aclk);
        instr_word <= w;
        instr_valid <= 1'b1;
        for (n = 0; n < 10; n++) begin
            @(posedge aclk);
            #1;
            if (!instr_ready) break;
        end
        if (n == 10) timed_out();
        @(posedge aclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task run_br(input logic [15:0] w, input logic [PC_W-1:0] pc,
                input logic z, input logic tk, input logic [PC_W-1:0] t);
        @(posedge aclk);
        pc_cur <= pc;
        zero_flag <= z;
        issue(w);
        chk(dmem_re, 1'b0);
        @(posedge aclk);
        #1;
        chk(pc_load, tk);
        if (tk) chk(pc_target, t);
        chk(dmem_we, 1'b0);
        @(posedge aclk);
        #1;
        chk(flush_fetch, tk);
        chk(instr_ready, !tk);
        if (tk) begin
            repeat (3) @(posedge aclk);
            #1;
            chk(flush_fetch, 1'b1);
            @(posedge aclk);
            #1;
            chk(flush_fetch, 1'b0);
            chk(instr_ready, 1'b1);
        end
    endtask

    task run_bit_set(input logic [15:0] w, input logic [DA_W-1:0] a,
                 input logic [7:0] rd, input logic [7:0] wd);
        @(posedge aclk);
        dmem_rdata <= rd;
        issue(w);
        chk(dmem_re, 1'b1);
        chk(dmem_addr, a);
        @(posedge aclk);
        #1;
        chk(dmem_we, 1'b1);
        chk(dmem_wdata, wd);
        chk(pc_load, 1'b0);
        @(posedge aclk);
        #1;
        chk(instr_ready, 1'b1);
    endtask

    // A word outside the three opcodes must never be taken.
    task run_other;
        @(posedge aclk);
        instr_word <= 16'hE700;
        instr_valid <= 1'b1;
        repeat (8) begin
            @(posedge aclk);
            #1;
            chk({instr_ready, pc_load, dmem_re}, 32'h4);
        end
        @(posedge aclk);
        instr_valid <= 1'b0;
    endtask

    initial begin
        aresetn = 1'b0;
        {awaddr, wdata, araddr, awvalid, wvalid, bready} = '0;
        {arvalid, rready, instr_valid, zero_flag} = '0;
        wstrb = 4'hF;
        instr_word = 16'h0000;
        pc_cur = '0;
        index_base = 12'hFF0;
        dmem_rdata = 8'h00;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        axi_rd(ADDR_BANK, 32'h0, RESP_OKAY);
        axi_rd(32'h10, 32'h0, RESP_SLVERR);
        axi_wr(32'h10, 32'h1, RESP_SLVERR);
        axi_wr(ADDR_TGT, 32'h55, RESP_OKAY);
        run_br(16'hE180, 21'h001000, 1'b0, 1'b1, 21'h000F00);
        run_br(16'hE17F, 21'h001000, 1'b1, 1'b0, 21'h0);
        run_br(16'hD3FF, 21'h001000, 1'b1, 1'b1, 21'h0017FE);
        run_br(16'hD400, 21'h000100, 1'b0, 1'b1, 21'h1FF900);
        axi_rd(ADDR_TGT, 32'h1FF900, RESP_OKAY);
        run_other();
        axi_wr(ADDR_BANK, 32'hA, RESP_OKAY);
        run_bit_set(16'h8F34, 12'hA34, 8'h0A, 8'h8A);
        run_bit_set(16'h8034, 12'h034, 8'h00, 8'h01);
        run_bit_set(16'h8660, 12'hF60, 8'hFF, 8'hFF);
        axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        run_bit_set(16'h845F, 12'h04F, 8'h10, 8'h14);
        run_bit_set(16'h8A60, 12'hF60, 8'h00, 8'h20);
        run_bit_set(16'h8310, 12'hA10, 8'h00, 8'h02);
        axi_rd(ADDR_CTRL, 32'h1, RESP_OKAY);
        axi_rd(ADDR_BANK, 32'hA, RESP_OKAY);
        // Idle state with the bit-set opcode left from the last instruction.
        axi_rd(ADDR_STAT, 32'hC, RESP_OKAY);
        stop_test();
    end
endmodule
